// [shared/qsb_pkg.sv]
package qsb_pkg;

    // data path shape
    localparam int DATA_W    = 36;   // word width
    localparam int LANES     = 4;    // byte lanes per word
    localparam int LANE_W    = 9;    // bits per byte lane
    localparam int ADDR_W    = 21;   // word address width
    localparam int BURST_LEN = 4;    // words per burst
    localparam int BEAT_W    = 2;    // burst word index width

    // read timing, one beat per rising edge of CLK_I
    localparam int RD_LATENCY_K = 2;  // input clock cycles to data
    localparam int BEATS_PER_K  = 2;  // half-cycle beats per input clock
    localparam int FETCH_DELAY  = RD_LATENCY_K * BEATS_PER_K - 1;
    localparam int RD_PIPE_W    = FETCH_DELAY + BURST_LEN - 1;

    // lock wait
    localparam int CLK_MHZ      = 40;  // CLK_I rate
    localparam int LOCK_TIME_US = 20;  // least lock time
    localparam int LOCK_CYCLES  = LOCK_TIME_US * CLK_MHZ;
    localparam int LOCK_CNT_W   = 10;

    // test port
    localparam int TAP_RESET_EDGES = 5;  // mode-high edges to reset
    localparam int TMS_CNT_W       = 3;

    // write buffer
    localparam int FIFO_DEPTH = 16;

    // reset values
    localparam logic              PHASE_RST = 1'b0;
    localparam logic [DATA_W-1:0] Q_RST     = 36'h000000000;

    // request sampled on the true clock beat
    typedef struct packed {
        logic              rd_n;   // read request, low active
        logic              wr_n;   // write request, low active
        logic [ADDR_W-1:0] addr;   // burst base address
    } qsb_req_t;

    // write data beat with its byte selects
    typedef struct packed {
        logic [LANES-1:0]  byte_write_select_n;
        logic [DATA_W-1:0] data;
    } qsb_wdata_t;

    // one buffered write word
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0]  byte_write_select_n;
        logic [DATA_W-1:0] data;
    } qsb_wbeat_t;

    // test logic state
    typedef enum logic [0:0] {
        TAP_LOGIC_RESET = 1'b0,
        TAP_ACTIVE      = 1'b1
    } qsb_tap_state_t;

endpackage

// [rtl/qsb_top.sv]
`timescale 1ns/1ps

// write word buffer
module qsb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // filling side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];    // storage
    logic [PW-1:0]    wr_ptr_q, wr_ptr_d;
    logic [PW-1:0]    rd_ptr_q, rd_ptr_d;
    logic [PW:0]      count_q, count_d;
    logic             push, pop;

    // honest full and empty
    assign in_ready_o  = (count_q != (PW+1)'(DEPTH));
    assign out_valid_o = (count_q != '0);
    assign out_data_o  = mem_q[rd_ptr_q];
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // pointer and count update
    always_comb begin
        wr_ptr_d = push ? wr_ptr_q + 1'b1 : wr_ptr_q;
        rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
        count_d  = count_q;
        if (push && !pop) begin
            count_d = count_q + 1'b1;
        end else if (pop && !push) begin
            count_d = count_q - 1'b1;
        end
    end

    // registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            wr_ptr_q <= wr_ptr_d;
            rd_ptr_q <= rd_ptr_d;
            count_q  <= count_d;
        end
    end

    // storage write, no reset needed
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end
endmodule // qsb_fifo

// burst memory data path
module qsb_top (
    // clock and reset
    input  wire logic                       CLK_I,
    input  wire logic                       RESETN_I,
    // request and write data
    input  wire qsb_pkg::qsb_req_t          REQ_I,
    input  wire qsb_pkg::qsb_wdata_t        WDATA_I,
    output logic                            WR_READY_O,
    // read data, echo and lock status
    output logic [qsb_pkg::DATA_W-1:0]      Q_O,
    output logic                            Q_OE_O,
    output logic                            QVLD_O,
    output logic                            ECHO_CLOCK_TRUE_O,
    output logic                            LOCKED_O,
    // test port
    input  wire logic                       TCK_I,
    input  wire logic                       TMS_I,
    input  wire logic                       TDI_I,
    output logic                            TDO_O,
    output logic                            TDO_OE_O,
    output logic                            TMS_PULLUP_O,
    output logic                            TDI_PULLUP_O,
    output logic                            TAP_RESET_O
);
    import qsb_pkg::*;

    logic                  phase_q, phase_d;      // 0 = true clock beat
    logic                  k_beat;                // true clock beat
    logic [LOCK_CNT_W-1:0] lock_cnt_q, lock_cnt_d;
    logic                  locked_q, locked_d;
    logic                  rd_go, wr_go;          // accepted requests
    logic                  wr_act_q, wr_act_d;    // write beats 1..3 due
    logic [BEAT_W-1:0]     wr_beat_q, wr_beat_d;
    logic [ADDR_W-1:0]     wr_base_q, wr_base_d;
    logic [BEAT_W-1:0]     wr_idx;                // beat now on data pins
    logic                  fifo_in_valid;
    qsb_wbeat_t            fifo_in, fifo_out;
    logic                  fifo_out_valid, drain_ready;
    logic                  fw_valid_q, fw_valid_d;      // forward burst held
    logic [ADDR_W-1:0]     fw_base_q, fw_base_d;
    logic [DATA_W-1:0]     fw_data_q [BURST_LEN];
    logic [DATA_W-1:0]     fw_data_d [BURST_LEN];
    logic [LANES-1:0]      fw_bw_q [BURST_LEN];
    logic [LANES-1:0]      fw_bw_d [BURST_LEN];
    logic [RD_PIPE_W-1:0]  rd_pipe_q, rd_pipe_d;  // request age shift
    logic [ADDR_W-1:0]     rd_addr_q, rd_addr_d;
    logic [ADDR_W-1:0]     fetch_base_q, fetch_base_d;
    logic                  fetch_act;
    logic [BEAT_W-1:0]     fetch_beat;
    logic [ADDR_W-1:0]     fetch_addr;
    logic [DATA_W-1:0]     fetch_word;            // array word, forwarded
    logic [DATA_W-1:0]     q_q, q_d;
    logic                  oe_q, oe_d;
    logic                  echo_q, echo_d;
    logic [DATA_W-1:0]     mem_q [2**ADDR_W];     // memory array

    // beat phase and lock timer
    always_comb begin
        phase_d    = ~phase_q;
        lock_cnt_d = locked_q ? lock_cnt_q : lock_cnt_q + 1'b1;
        // flag holds once set, the counter stops one past the limit
        locked_d   = locked_q | (lock_cnt_q == LOCK_CNT_W'(LOCK_CYCLES));
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            phase_q    <= PHASE_RST;
            lock_cnt_q <= '0;
            locked_q   <= 1'b0;
        end else begin
            phase_q    <= phase_d;
            lock_cnt_q <= lock_cnt_d;
            locked_q   <= locked_d;
        end
    end

    assign k_beat   = ~phase_q;
    assign LOCKED_O = locked_q;

    // request acceptance on the true clock only
    assign rd_go = k_beat & ~REQ_I.rd_n & locked_q
                 & (rd_pipe_q[BURST_LEN-2:0] == '0);
    assign wr_go = k_beat & ~REQ_I.wr_n & locked_q
                 & ~wr_act_q & WR_READY_O;

    // write beat sequencing, beat 0 in request cycle
    always_comb begin
        wr_act_d  = wr_act_q;
        wr_beat_d = wr_beat_q;
        wr_base_d = wr_base_q;
        if (wr_go) begin
            wr_act_d  = 1'b1;
            wr_beat_d = BEAT_W'(1);
            wr_base_d = REQ_I.addr;
        end else if (wr_act_q) begin
            wr_beat_d = wr_beat_q + 1'b1;
            wr_act_d  = (wr_beat_q != BEAT_W'(BURST_LEN-1));
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            wr_act_q  <= 1'b0;
            wr_beat_q <= '0;
            wr_base_q <= '0;
        end else begin
            wr_act_q  <= wr_act_d;
            wr_beat_q <= wr_beat_d;
            wr_base_q <= wr_base_d;
        end
    end

    // select and data of one beat travel together
    always_comb begin
        wr_idx        = wr_go ? '0 : wr_beat_q;
        fifo_in_valid = wr_go | wr_act_q;
        fifo_in.addr  = wr_go ? REQ_I.addr
                              : wr_base_q + ADDR_W'(wr_beat_q);
        fifo_in.byte_write_select_n = WDATA_I.byte_write_select_n;
        fifo_in.data  = WDATA_I.data;
    end

    // latest write burst kept for forwarding
    always_comb begin
        fw_valid_d = fw_valid_q;
        fw_base_d  = fw_base_q;
        fw_data_d  = fw_data_q;
        fw_bw_d    = fw_bw_q;
        if (wr_go) begin
            fw_valid_d = 1'b1;
            fw_base_d  = REQ_I.addr;
            for (int k = 0; k < BURST_LEN; k++) begin
                fw_bw_d[k] = '1;                          // clear old burst
            end
        end
        if (fifo_in_valid) begin
            fw_data_d[wr_idx] = WDATA_I.data;
            fw_bw_d[wr_idx]   = WDATA_I.byte_write_select_n;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            fw_valid_q <= 1'b0;
            fw_base_q  <= '0;
            for (int k = 0; k < BURST_LEN; k++) begin
                fw_data_q[k] <= '0;
                fw_bw_q[k]   <= '1;
            end
        end else begin
            fw_valid_q <= fw_valid_d;
            fw_base_q  <= fw_base_d;
            fw_data_q  <= fw_data_d;
            fw_bw_q    <= fw_bw_d;
        end
    end

    // write buffer between pins and array
    qsb_fifo #(
        .WIDTH ($bits(qsb_wbeat_t)),
        .DEPTH (FIFO_DEPTH)
    ) u_wbuf (
        .clk_i       (CLK_I),
        .rst_n_i     (RESETN_I),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (WR_READY_O),
        .in_data_i   (fifo_in),
        .out_valid_o (fifo_out_valid),
        .out_ready_i (drain_ready),
        .out_data_o  (fifo_out)
    );

    // drain stalls when the fetch reads the same word
    assign drain_ready = ~(fetch_act && (fifo_out.addr == fetch_addr));

    // array write per byte lane, selects low active
    always_ff @(posedge CLK_I) begin
        for (int l = 0; l < LANES; l++) begin
            if (fifo_out_valid && drain_ready
                && !fifo_out.byte_write_select_n[l]) begin
                mem_q[fifo_out.addr][l*LANE_W +: LANE_W]
                    <= fifo_out.data[l*LANE_W +: LANE_W];
            end
        end
    end

    // read fetch position from request age
    always_comb begin
        fetch_act  = 1'b0;
        fetch_beat = '0;
        for (int k = 0; k < BURST_LEN; k++) begin
            if (rd_pipe_q[FETCH_DELAY-1+k]) begin
                fetch_act  = 1'b1;
                fetch_beat = BEAT_W'(k);
            end
        end
        fetch_addr = fetch_base_q + ADDR_W'(fetch_beat);
        fetch_word = mem_q[fetch_addr];
        // newest write to this burst overrides the array
        if (fw_valid_q && (fw_base_q == fetch_base_q)) begin
            for (int l = 0; l < LANES; l++) begin
                if (!fw_bw_q[fetch_beat][l]) begin
                    fetch_word[l*LANE_W +: LANE_W] =
                        fw_data_q[fetch_beat][l*LANE_W +: LANE_W];
                end
            end
        end
    end

    // read pipeline and output drive
    always_comb begin
        rd_pipe_d    = {rd_pipe_q[RD_PIPE_W-2:0], rd_go};
        rd_addr_d    = rd_go ? REQ_I.addr : rd_addr_q;
        fetch_base_d = rd_pipe_q[FETCH_DELAY-2] ? rd_addr_q
                                                : fetch_base_q;
        q_d          = fetch_act ? fetch_word : Q_RST;
        oe_d         = fetch_act;
        echo_d       = ~phase_d;
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            rd_pipe_q    <= '0;
            rd_addr_q    <= '0;
            fetch_base_q <= '0;
            q_q          <= Q_RST;
            oe_q         <= 1'b0;
            echo_q       <= 1'b0;
        end else begin
            rd_pipe_q    <= rd_pipe_d;
            rd_addr_q    <= rd_addr_d;
            fetch_base_q <= fetch_base_d;
            q_q          <= q_d;
            oe_q         <= oe_d;
            echo_q       <= echo_d;
        end
    end

    assign Q_O               = q_q;
    assign Q_OE_O            = oe_q;
    assign QVLD_O            = oe_q;
    assign ECHO_CLOCK_TRUE_O = echo_q;

    // test port, isolated from the data path
    logic           tck_s1_q, tck_s2_q, tck_s3_q;
    logic           tms_s1_q, tms_s2_q;
    logic           tck_rise;
    qsb_tap_state_t tap_q, tap_d;
    logic [TMS_CNT_W-1:0] tms_cnt_q, tms_cnt_d;

    assign tck_rise = tck_s2_q & ~tck_s3_q;

    // mode-high edge count drives the reset state
    always_comb begin
        tap_d     = tap_q;
        tms_cnt_d = tms_cnt_q;
        if (tck_rise) begin
            if (tms_s2_q) begin
                if (tms_cnt_q != TMS_CNT_W'(TAP_RESET_EDGES)) begin
                    tms_cnt_d = tms_cnt_q + 1'b1;
                end
                if (tms_cnt_q == TMS_CNT_W'(TAP_RESET_EDGES-1)) begin
                    tap_d = TAP_LOGIC_RESET;
                end
            end else begin
                tms_cnt_d = '0;
                tap_d     = TAP_ACTIVE;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            tck_s1_q  <= 1'b0;
            tck_s2_q  <= 1'b0;
            tck_s3_q  <= 1'b0;
            tms_s1_q  <= 1'b1;
            tms_s2_q  <= 1'b1;
            tap_q     <= TAP_LOGIC_RESET;
            tms_cnt_q <= '0;
        end else begin
            tck_s1_q  <= TCK_I;
            tck_s2_q  <= tck_s1_q;
            tck_s3_q  <= tck_s2_q;
            tms_s1_q  <= TMS_I;
            tms_s2_q  <= tms_s1_q;
            tap_q     <= tap_d;
            tms_cnt_q <= tms_cnt_d;
        end
    end

    assign TAP_RESET_O  = (tap_q == TAP_LOGIC_RESET);
    assign TDO_O        = 1'b0;
    assign TDO_OE_O     = 1'b0;
    assign TMS_PULLUP_O = 1'b1;
    assign TDI_PULLUP_O = 1'b1;

    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence s_read_burst;
        Q_OE_O [*4];
    endsequence

    sequence s_read_quiet;
        rd_go ##1 (!rd_go) [*4];
    endsequence

    chk_read_first_word: assert property (
        rd_go |-> ##4 s_read_burst)
        else $error("read burst not on outputs at latency");
    chk_read_output_off: assert property (
        s_read_quiet |-> ##4 !Q_OE_O)
        else $error("read outputs still driven after burst");
    chk_burst_addr_step: assert property (
        fetch_act && (fetch_beat != '0)
        |-> fetch_addr == $past(fetch_addr) + ADDR_W'(1))
        else $error("burst address did not step by one");
    chk_write_forward: assert property (
        rd_go && wr_go && (WDATA_I.byte_write_select_n == '0)
        |-> ##4 Q_O == $past(WDATA_I.data, 4))
        else $error("written word not forwarded to read");
    chk_tap_reset_entry: assert property (
        $rose(TAP_RESET_O) |-> $past(tck_rise) && $past(tms_s2_q)
        && $past(tms_cnt_q) == TMS_CNT_W'(TAP_RESET_EDGES-1))
        else $error("test reset entered without five edges");
    chk_tap_isolated: assert property (
        !TDO_OE_O && TMS_PULLUP_O && TDI_PULLUP_O)
        else $error("test port drives or lost pull-ups");
    chk_idle_before_lock: assert property (
        !LOCKED_O |-> !rd_go && !wr_go)
        else $error("request taken before lock");
    chk_write_beats: assert property (
        wr_go |-> fifo_in_valid [*4])
        else $error("write burst not four beats");
    chk_true_clock_req: assert property (
        (rd_go || wr_go) |-> !phase_q && ECHO_CLOCK_TRUE_O)
        else $error("request taken off the true clock");
endmodule // qsb_top

// [tb/qsb_ctrl_model.sv]
`timescale 1ns/1ps

// far-side controller: requests and write beats
module qsb_ctrl_model (
    // clock and device status
    input  wire logic           clk_i,
    input  wire logic           echo_i,
    input  wire logic           locked_i,
    // request and write beats
    output qsb_pkg::qsb_req_t   req_o,
    output qsb_pkg::qsb_wdata_t wdata_o
);
    import qsb_pkg::*;

    // idle: no request, selects off
    initial begin
        req_o   = '{rd_n: 1'b1, wr_n: 1'b1, addr: '0};
        wdata_o = '{byte_write_select_n: '1, data: '0};
    end

    // one request, write beats from the request cycle on
    task automatic issue(input logic rd, input logic wr,
                         input logic [ADDR_W-1:0] a, input logic early,
                         input logic [3:0][DATA_W-1:0] d,
                         input logic [3:0][LANES-1:0] bw);
        // hold off until the lock time is over, unless early is set
        while (!early && locked_i !== 1'b1) @(posedge clk_i);
        // complement beat now, so the next edge opens a true beat
        do @(negedge clk_i); while (echo_i !== 1'b0);
        @(posedge clk_i);
        req_o   <= '{rd_n: ~rd, wr_n: ~wr, addr: a};
        wdata_o <= '{bw[0], d[0]};
        for (int k = 1; k < 4; k++) begin
            @(posedge clk_i);
            // address hold over: show its inverse
            req_o   <= '{rd_n: 1'b1, wr_n: 1'b1, addr: ~a};
            wdata_o <= '{bw[k], d[k]};
        end
        @(posedge clk_i);
        // data released: inverse of the last beat
        wdata_o <= '{~bw[3], ~d[3]};
    endtask
endmodule // qsb_ctrl_model

// [tb/qsb_top_tb.sv]
`timescale 1ns/1ps

// bench for the burst memory data path
module qsb_top_tb;
    import qsb_pkg::*;

    typedef logic [3:0][DATA_W-1:0] qsb_words_t; // four burst words
    typedef logic [3:0][LANES-1:0]  qsb_sels_t;  // four select beats

    logic              clk;      // 40 MHz clock
    logic              rst_n;    // sync reset, low active
    qsb_req_t          req;      // request from controller
    qsb_wdata_t        wdata;    // write beat from controller
    logic              wr_ready;
    logic [DATA_W-1:0] q;
    logic              q_oe, qvld, echo, locked;
    logic              tck, tms, tdo, tdo_oe, tms_pu, tdi_pu, tap_rst;
    wire logic         tdi;      // left open, pull-up decides
    int                errors, num_checks;

    // unconnected test data pin settles at its pull-up
    assign tdi = tdi_pu;

    qsb_top i_qsb_top (.CLK_I(clk), .RESETN_I(rst_n), .REQ_I(req),
        .WDATA_I(wdata), .WR_READY_O(wr_ready), .Q_O(q), .Q_OE_O(q_oe),
        .QVLD_O(qvld), .ECHO_CLOCK_TRUE_O(echo), .LOCKED_O(locked),
        .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TDO_O(tdo),
        .TDO_OE_O(tdo_oe), .TMS_PULLUP_O(tms_pu), .TDI_PULLUP_O(tdi_pu),
        .TAP_RESET_O(tap_rst));
    qsb_ctrl_model i_qsb_ctrl_model (.clk_i(clk), .echo_i(echo),
        .locked_i(locked), .req_o(req), .wdata_o(wdata));

    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // compare one value and count it
    task automatic check(input string what, input logic [DATA_W-1:0] exp,
                         input logic [DATA_W-1:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // verdict and end of run
    task automatic close_out;
        $display("errors %0d checks %0d", errors, num_checks);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // four words in successive cycles, then outputs off
    task automatic rd_words(input qsb_words_t exp);
        for (int k = 0; k < 4; k++) begin
            @(negedge clk);
            check("read valid", 36'h3, 36'({q_oe, qvld}));
            check("read word", exp[k], q);
            check("echo beat", 36'(k % 2 == 0), 36'(echo));
        end
        @(negedge clk);
        check("read off", 36'h0, 36'({q_oe, qvld, |q}));
    endtask

    // pin values straight after reset
    task automatic t_reset;
        check("reset pins", 36'h17, 36'({q_oe, qvld, locked, tap_rst,
              tdo_oe, tms_pu, tdi_pu, wr_ready}));
        check("reset data", 36'h0, q);
        check("test data out", 36'h0, 36'({tdo, tdo_oe}));
    endtask

    // early read ignored, lock comes after the wait
    task automatic t_lock;
        int n;
        n = 0;
        fork
            begin
                i_qsb_ctrl_model.issue(1'b1, 1'b0, 21'h000010, 1'b1, '0, '1);
                repeat (8) begin
                    @(negedge clk);
                    check("early read", 36'h0, 36'(q_oe));
                end
            end
            while (locked !== 1'b1 && n < 900) begin
                @(negedge clk);
                n++;
            end
        join
        check("lock span", 36'h1, 36'(n >= 795 && n <= 805));
        repeat (4) @(negedge clk);
        check("lock held", 36'h1, 36'(locked));
    endtask

    // one test clock pulse, wide enough for the synchronisers
    task automatic tck_pulse(input logic mode);
        @(posedge clk);
        tms <= mode;
        repeat (4) @(posedge clk);
        tck <= 1'b1;
        repeat (4) @(posedge clk);
        tck <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    // leave reset, then four high is short of five
    task automatic t_tap;
        tck_pulse(1'b0);
        check("tap leave", 36'h0, 36'(tap_rst));
        repeat (4) tck_pulse(1'b1);
        check("tap four", 36'h0, 36'(tap_rst));
        tck_pulse(1'b1);
        check("tap five", 36'h1, 36'(tap_rst));
    endtask

    // burst order across the top of the address space
    task automatic t_order;
        qsb_words_t d, e, x;
        for (int k = 0; k < 4; k++) begin
            d[k] = 36'hA5A5A5A50 + 36'(k);
            e[k] = 36'h5A5A5A5A0 + 36'(k);
        end
        x = {e[1], e[0], d[3], d[2]};
        i_qsb_ctrl_model.issue(1'b0, 1'b1, 21'h1FFFFE, 1'b0, d, '0);
        i_qsb_ctrl_model.issue(1'b0, 1'b1, 21'h000002, 1'b0, e, '0);
        i_qsb_ctrl_model.issue(1'b1, 1'b0, 21'h1FFFFE, 1'b0, '0, '1);
        rd_words(d);
        i_qsb_ctrl_model.issue(1'b1, 1'b0, 21'h000000, 1'b0, '0, '1);
        rd_words(x);
    endtask

    // read with a partial write to the same base in one cycle
    task automatic t_forward;
        qsb_sels_t  bw;
        qsb_words_t o, n, x;
        bw = {4'hF, 4'hA, 4'h5, 4'h0};
        for (int k = 0; k < 4; k++) begin
            o[k] = 36'h123456780 + 36'(k);
            n[k] = 36'hFEDCBA980 + 36'(k);
            for (int l = 0; l < LANES; l++)
                x[k][l*LANE_W +: LANE_W] = bw[k][l] ?
                    o[k][l*LANE_W +: LANE_W] : n[k][l*LANE_W +: LANE_W];
        end
        i_qsb_ctrl_model.issue(1'b0, 1'b1, 21'h00ABCD, 1'b0, o, '0);
        i_qsb_ctrl_model.issue(1'b1, 1'b1, 21'h00ABCD, 1'b0, n, bw);
        rd_words(x);
    endtask

    // main sequence
    initial begin
        rst_n      = 1'b0;
        tck        = 1'b0;
        tms        = 1'b1;
        errors     = 0;
        num_checks = 0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_reset;
        t_lock;
        t_tap;
        t_order;
        t_forward;
        close_out;
    end

    // hang guard, well past the expected run
    initial begin
        repeat (5000) @(posedge clk);
        errors++;
        close_out;
    end
endmodule // qsb_top_tb
